/* hw/ssc_core.sv */
// Top of the shift, subtract and carry execution slice with its register file.
// Assumes an AXI4-Lite master on aclk; software loads an instruction and starts it.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module ssc_core
  import ssc_pkg::*;
#(
  parameter int RF_AW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {S_IDLE, S_RESOLVE, S_EXEC} ssc_state_e;

  ssc_state_e state_reg;
  logic [7:0] rf_mem [1 << RF_AW];
  logic [31:0] instr_reg;
  logic [7:0] register_pointer_reg;
  ssc_flags_s flags_reg;
  logic [RF_AW-1:0] rf_addr_reg;
  logic done_reg;
  logic illegal_reg;
  logic [RF_AW-1:0] src_addr_reg;
  logic [RF_AW-1:0] dst_addr_reg;
  logic [7:0] literal_operand_reg;
  logic src_lit_reg;
  ssc_op_e kind_reg;

  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rvalid_reg;

  logic busy;
  logic do_wr;
  logic wr_err;
  logic start;
  logic [7:0] opc;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;

  ssc_op_e kind_next;
  logic [RF_AW-1:0] src_addr_next;
  logic [RF_AW-1:0] dst_addr_next;
  logic [7:0] literal_operand_next;
  logic src_lit_next;
  logic illegal_next;

  ssc_alu_if alu_bus ();

  ssc_alu u_alu (
    .bus(alu_bus)
  );

  // Working register n: pointer page, pointer group, n
  function automatic logic [11:0] wreg_addr(input logic [3:0] n, input logic [7:0] rp);
    wreg_addr = {rp[3:0], rp[7:4], n};
  endfunction : wreg_addr

  // 8-bit direct address; E0H..EFH never reach the register itself
  function automatic logic [11:0] res8(input logic [7:0] a, input logic [7:0] rp);
    if (a[7:4] == `SSC_ESC_NIBBLE) begin
      res8 = wreg_addr(a[3:0], rp);
    end else begin
      res8 = {rp[3:0], a};
    end
  endfunction : res8

  // 12-bit extended address; only EE0H..EEFH escape to working registers, the rest of page E is direct
  function automatic logic [11:0] res12(input logic [11:0] a, input logic [7:0] rp);
    if (a[11:4] == `SSC_ESC_BYTE) begin
      res12 = wreg_addr(a[3:0], rp);
    end else begin
      res12 = a;
    end
  endfunction : res12

  // Indirect operands: the pointer byte is not escaped, which is how E0H..EFH stay reachable
  function automatic logic [11:0] ind_addr(input logic [7:0] ptr, input logic [7:0] rp);
    ind_addr = {rp[3:0], ptr};
  endfunction : ind_addr

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_off);
    addr_is = (a[7:2] == reg_off[7:2]);
  endfunction : addr_is

  assign opc = instr_reg[7:0];
  assign b1 = instr_reg[15:8];
  assign b2 = instr_reg[23:16];
  assign b3 = instr_reg[31:24];
  assign busy = (state_reg != S_IDLE);

  // Operand decode
  always_comb begin
    kind_next = OP_SBC;
    src_addr_next = '0;
    dst_addr_next = '0;
    literal_operand_next = 8'h00;
    src_lit_next = 1'b0;
    illegal_next = 1'b0;
    case (opc)
      `SSC_OPC_SBC_WW: begin
        dst_addr_next = wreg_addr(b1[7:4], register_pointer_reg);
        src_addr_next = wreg_addr(b1[3:0], register_pointer_reg);
      end
      `SSC_OPC_SBC_WI: begin
        dst_addr_next = wreg_addr(b1[7:4], register_pointer_reg);
        src_addr_next = ind_addr(rf_mem[wreg_addr(b1[3:0], register_pointer_reg)], register_pointer_reg);
      end
      `SSC_OPC_SBC_RR: begin
        src_addr_next = res8(b1, register_pointer_reg);
        dst_addr_next = res8(b2, register_pointer_reg);
      end
      `SSC_OPC_SBC_RI: begin
        src_addr_next = ind_addr(rf_mem[res8(b1, register_pointer_reg)], register_pointer_reg);
        dst_addr_next = res8(b2, register_pointer_reg);
      end
      `SSC_OPC_SBC_RM: begin
        dst_addr_next = res8(b1, register_pointer_reg);
        literal_operand_next = b2;
        src_lit_next = 1'b1;
      end
      `SSC_OPC_SBC_IM: begin
        dst_addr_next = ind_addr(rf_mem[res8(b1, register_pointer_reg)], register_pointer_reg);
        literal_operand_next = b2;
        src_lit_next = 1'b1;
      end
      `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EE: begin
        src_addr_next = res12({b1, b2[7:4]}, register_pointer_reg);
        dst_addr_next = res12({b2[3:0], b3}, register_pointer_reg);
      end
      `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EM: begin
        literal_operand_next = b1;
        src_lit_next = 1'b1;
        dst_addr_next = res12({b2[3:0], b3}, register_pointer_reg);
      end
      `SSC_OPC_RRC_R, `SSC_OPC_RRC_I: begin
        kind_next = OP_RRC;
        dst_addr_next = (opc[0]) ? ind_addr(rf_mem[res8(b1, register_pointer_reg)], register_pointer_reg)
                                 : res8(b1, register_pointer_reg);
      end
      `SSC_OPC_SRA_R, `SSC_OPC_SRA_I: begin
        kind_next = OP_SRA;
        dst_addr_next = (opc[0]) ? ind_addr(rf_mem[res8(b1, register_pointer_reg)], register_pointer_reg)
                                 : res8(b1, register_pointer_reg);
      end
      `SSC_OPC_SCF: begin
        kind_next = OP_SCF;
      end
      default: begin
        kind_next = OP_NONE;
        illegal_next = 1'b1;
      end
    endcase
  end

  assign alu_bus.kind = (state_reg == S_EXEC) ? kind_reg : OP_NONE;
  assign alu_bus.a = rf_mem[dst_addr_reg];
  assign alu_bus.b = src_lit_reg ? literal_operand_reg : rf_mem[src_addr_reg];
  assign alu_bus.fin = flags_reg;

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      kind_reg <= OP_NONE;
      src_addr_reg <= '0;
      dst_addr_reg <= '0;
      literal_operand_reg <= 8'h00;
      src_lit_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            state_reg <= S_RESOLVE;
          end
        end
        S_RESOLVE: begin
          kind_reg <= kind_next;
          src_addr_reg <= src_addr_next;
          dst_addr_reg <= dst_addr_next;
          literal_operand_reg <= literal_operand_next;
          src_lit_reg <= src_lit_next;
          state_reg <= illegal_next ? S_IDLE : S_EXEC;
        end
        S_EXEC: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Completion status; start only comes while idle so set and clear never meet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (start) begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (state_reg == S_EXEC) begin
      done_reg <= 1'b1;
    end else if (state_reg == S_RESOLVE && illegal_next) begin
      done_reg <= 1'b1;
      illegal_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= `SSC_FLAGS_RST;
    end else if (state_reg == S_EXEC) begin
      flags_reg <= alu_bus.fout;
    end else if (do_wr && !wr_err && addr_is(aw_addr_reg, `SSC_REG_FLAGS) && w_strb_reg[0]) begin
      flags_reg <= w_data_reg[`SSC_FLAGS_LSB +: 6];
    end
  end

  // Register file: no reset, it is data storage
  always_ff @(posedge aclk) begin
    if (state_reg == S_EXEC && alu_bus.wr) begin
      rf_mem[dst_addr_reg] <= alu_bus.res;
    end else if (do_wr && !wr_err && addr_is(aw_addr_reg, `SSC_REG_RF_DATA) && w_strb_reg[0]) begin
      rf_mem[rf_addr_reg] <= w_data_reg[7:0];
    end
  end

  // AXI4-Lite write side; address and data are taken in either order
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
  // Writes that would disturb a running instruction are refused rather than stalled
  assign wr_err = !(addr_is(aw_addr_reg, `SSC_REG_CTRL) || addr_is(aw_addr_reg, `SSC_REG_INSTR) ||
                    addr_is(aw_addr_reg, `SSC_REG_RP) || addr_is(aw_addr_reg, `SSC_REG_FLAGS) ||
                    addr_is(aw_addr_reg, `SSC_REG_STATUS) || addr_is(aw_addr_reg, `SSC_REG_RF_ADDR) ||
                    addr_is(aw_addr_reg, `SSC_REG_RF_DATA)) ||
                  (busy && !addr_is(aw_addr_reg, `SSC_REG_STATUS));
  assign start = do_wr && !wr_err && addr_is(aw_addr_reg, `SSC_REG_CTRL) &&
                 w_strb_reg[0] && w_data_reg[`SSC_CTRL_START_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_err ? `SSC_RESP_SLVERR : `SSC_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Software-written configuration steering the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= `SSC_INSTR_RST;
      register_pointer_reg <= `SSC_RP_RST;
      rf_addr_reg <= `SSC_RF_ADDR_RST;
    end else if (do_wr && !wr_err) begin
      if (addr_is(aw_addr_reg, `SSC_REG_INSTR)) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb_reg[i]) begin
            instr_reg[8*i +: 8] <= w_data_reg[8*i +: 8];
          end
        end
      end
      if (addr_is(aw_addr_reg, `SSC_REG_RP) && w_strb_reg[0]) begin
        register_pointer_reg <= w_data_reg[7:0];
      end
      if (addr_is(aw_addr_reg, `SSC_REG_RF_ADDR)) begin
        rf_addr_reg <= w_data_reg[RF_AW-1:0];
      end
    end
  end

  // AXI4-Lite read side, one cycle after the address is taken
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `SSC_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      if (addr_is(s_axi_araddr, `SSC_REG_INSTR)) begin
        rdata_reg <= instr_reg;
      end else if (addr_is(s_axi_araddr, `SSC_REG_RP)) begin
        rdata_reg <= {24'h000000, register_pointer_reg};
      end else if (addr_is(s_axi_araddr, `SSC_REG_FLAGS)) begin
        rdata_reg <= {24'h000000, flags_reg, 2'h0};
      end else if (addr_is(s_axi_araddr, `SSC_REG_STATUS)) begin
        rdata_reg <= {29'h00000000, illegal_reg, done_reg, busy};
      end else if (addr_is(s_axi_araddr, `SSC_REG_RF_ADDR)) begin
        rdata_reg <= {{(32-RF_AW){1'b0}}, rf_addr_reg};
      end else if (addr_is(s_axi_araddr, `SSC_REG_RF_DATA)) begin
        rdata_reg <= {24'h000000, rf_mem[rf_addr_reg]};
      end else if (!addr_is(s_axi_araddr, `SSC_REG_CTRL)) begin
        rresp_reg <= `SSC_RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Snapshot of each executed instruction, read only by the checks below
  logic chk_v_q;
  ssc_op_e chk_kind_q;
  logic [7:0] chk_a_q;
  logic [7:0] chk_b_q;
  ssc_flags_s chk_f_q;
  logic [RF_AW-1:0] chk_dst_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_v_q <= 1'b0;
      chk_kind_q <= OP_NONE;
      chk_a_q <= 8'h00;
      chk_b_q <= 8'h00;
      chk_f_q <= `SSC_FLAGS_RST;
      chk_dst_q <= '0;
    end else begin
      chk_v_q <= (state_reg == S_EXEC);
      chk_kind_q <= kind_reg;
      chk_a_q <= alu_bus.a;
      chk_b_q <= alu_bus.b;
      chk_f_q <= flags_reg;
      chk_dst_q <= dst_addr_reg;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rrc_shift;
    chk_v_q && chk_kind_q == OP_RRC |-> rf_mem[chk_dst_q] == {chk_f_q.c, chk_a_q[7:1]} && flags_reg.c == chk_a_q[0];
  endproperty
  a_rrc_shift: assert property (p_rrc_shift) else $error("rotate result or carry wrong");

  property p_rrc_flags;
    chk_v_q && chk_kind_q == OP_RRC |-> flags_reg.d == chk_f_q.d && flags_reg.h == chk_f_q.h &&
      flags_reg.s == rf_mem[chk_dst_q][7] && flags_reg.z == (rf_mem[chk_dst_q] == 8'h00);
  endproperty
  a_rrc_flags: assert property (p_rrc_flags) else $error("rotate flags wrong");

  property p_escape_one_op;
    state_reg == S_RESOLVE && opc == `SSC_OPC_RRC_R && b1[7:4] == `SSC_ESC_NIBBLE |=>
      dst_addr_reg == {register_pointer_reg[3:0], register_pointer_reg[7:4], b1[3:0]};
  endproperty
  a_escape_one_op: assert property (p_escape_one_op) else $error("working escape not applied");

  property p_escape_two_op;
    state_reg == S_RESOLVE && opc == `SSC_OPC_SBC_RR && b1[7:4] == `SSC_ESC_NIBBLE |=>
      src_addr_reg == {register_pointer_reg[3:0], register_pointer_reg[7:4], b1[3:0]};
  endproperty
  a_escape_two_op: assert property (p_escape_two_op) else $error("source escape not applied");

  property p_sbc_value;
    chk_v_q && chk_kind_q == OP_SBC |-> rf_mem[chk_dst_q] == 8'(chk_a_q - chk_b_q - {7'h00, chk_f_q.c});
  endproperty
  a_sbc_value: assert property (p_sbc_value) else $error("subtract result wrong");

  property p_sbc_flags;
    chk_v_q && chk_kind_q == OP_SBC |-> flags_reg.d && flags_reg.c == ({1'b0, chk_a_q} < 9'({1'b0, chk_b_q} + chk_f_q.c)) &&
      flags_reg.h == ({1'b0, chk_a_q[3:0]} < 5'({1'b0, chk_b_q[3:0]} + chk_f_q.c));
  endproperty
  a_sbc_flags: assert property (p_sbc_flags) else $error("subtract flags wrong");

  property p_ext_escape;
    state_reg == S_RESOLVE && opc == `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EE && b1 == `SSC_ESC_BYTE |=>
      src_addr_reg == {register_pointer_reg[3:0], register_pointer_reg[7:4], b2[7:4]};
  endproperty
  a_ext_escape: assert property (p_ext_escape) else $error("extended escape wrong");

  property p_scf;
    chk_v_q && chk_kind_q == OP_SCF |-> flags_reg == {1'b1, chk_f_q.z, chk_f_q.s, chk_f_q.v, chk_f_q.d, chk_f_q.h};
  endproperty
  a_scf: assert property (p_scf) else $error("set carry disturbed flags");

  property p_sra;
    chk_v_q && chk_kind_q == OP_SRA |-> rf_mem[chk_dst_q] == {chk_a_q[7], chk_a_q[7:1]} && !flags_reg.v &&
      flags_reg.c == chk_a_q[0] && flags_reg.d == chk_f_q.d && flags_reg.h == chk_f_q.h;
  endproperty
  a_sra: assert property (p_sra) else $error("arithmetic shift wrong");

  c_rrc: cover property (chk_v_q && chk_kind_q == OP_RRC);
  c_subtract_borrow_extended: cover property (state_reg == S_RESOLVE && opc == `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EE ##2 done_reg);
  c_scf: cover property (chk_v_q && chk_kind_q == OP_SCF);
  c_sra: cover property (chk_v_q && chk_kind_q == OP_SRA);

endmodule : ssc_core

`default_nettype wire

/* hw/ssc_params.svh */
// Constants of the shift, subtract and carry execution slice.
// Included by the core module and the bench; holds definitions only.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// Register map (byte addresses on the AXI4-Lite port)
`define SSC_REG_CTRL 8'h00
`define SSC_REG_INSTR 8'h04
`define SSC_REG_RP 8'h08
`define SSC_REG_FLAGS 8'h0C
`define SSC_REG_STATUS 8'h10
`define SSC_REG_RF_ADDR 8'h14
`define SSC_REG_RF_DATA 8'h18

// Field positions
`define SSC_CTRL_START_BIT 0
`define SSC_STAT_BUSY_BIT 0
`define SSC_STAT_DONE_BIT 1
`define SSC_STAT_ILLEGAL_BIT 2
`define SSC_FLAGS_LSB 2

// Reset values
`define SSC_RP_RST 8'h00
`define SSC_FLAGS_RST 6'h00
`define SSC_INSTR_RST 32'h0000_0000
`define SSC_RF_ADDR_RST 12'h000

// Escape codes for working-register operands
`define SSC_ESC_NIBBLE 4'hE
`define SSC_ESC_BYTE 8'hEE

// Opcodes
`define SSC_OPC_SBC_WW 8'h32
`define SSC_OPC_SBC_WI 8'h33
`define SSC_OPC_SBC_RR 8'h34
`define SSC_OPC_SBC_RI 8'h35
`define SSC_OPC_SBC_RM 8'h36
`define SSC_OPC_SBC_IM 8'h37
`define SSC_OPC_SUBTRACT_BORROW_EXTENDED_EE 8'h38
`define SSC_OPC_SUBTRACT_BORROW_EXTENDED_EM 8'h39
`define SSC_OPC_RRC_R 8'hC0
`define SSC_OPC_RRC_I 8'hC1
`define SSC_OPC_SRA_R 8'hD0
`define SSC_OPC_SRA_I 8'hD1
`define SSC_OPC_SCF 8'hDF

// AXI responses
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2

`endif

/* hw/ssc_pkg.sv */
// Types shared by the execution slice modules.
// Assumes ssc_params.svh is on the include path.
package ssc_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RRC,
    OP_SRA,
    OP_SCF,
    OP_SBC
  } ssc_op_e;

  // Packed so that the flag byte maps C..H onto bits 7..2
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } ssc_flags_s;

endpackage : ssc_pkg

/* hw/ssc_alu_if.sv */
// Signals between the sequencing core and its arithmetic unit.
// Assumes the package has been compiled first.
`timescale 1ns/1ps
`default_nettype none

interface ssc_alu_if;
  import ssc_pkg::*;
  ssc_op_e kind;
  logic [7:0] a;
  logic [7:0] b;
  ssc_flags_s fin;
  logic [7:0] res;
  ssc_flags_s fout;
  logic wr;

  modport core (output kind, output a, output b, output fin, input res, input fout, input wr);
  modport alu (input kind, input a, input b, input fin, output res, output fout, output wr);
endinterface : ssc_alu_if

`default_nettype wire

/* hw/ssc_alu.sv */
// Combinational arithmetic of the slice: rotate, shift, set-carry, subtract with borrow.
// Assumes the core holds operands stable for the cycle in which it writes back.
`timescale 1ns/1ps
`default_nettype none

module ssc_alu
  import ssc_pkg::*;
(
  ssc_alu_if.alu bus
);

  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    bus.res = bus.a;
    bus.fout = bus.fin;
    bus.wr = 1'b0;
    sum9 = 9'h000;
    nib5 = 5'h00;
    case (bus.kind)
      OP_RRC: begin
        bus.res = {bus.fin.c, bus.a[7:1]};
        bus.fout.c = bus.a[0];
        bus.fout.z = (bus.res == 8'h00);
        bus.fout.s = bus.res[7];
        bus.fout.v = bus.res[7] ^ bus.a[7];
        bus.wr = 1'b1;
      end
      OP_SRA: begin
        bus.res = {bus.a[7], bus.a[7:1]};
        bus.fout.c = bus.a[0];
        bus.fout.z = (bus.res == 8'h00);
        bus.fout.s = bus.res[7];
        bus.fout.v = 1'b0;
        bus.wr = 1'b1;
      end
      OP_SCF: begin
        bus.fout.c = 1'b1;
      end
      OP_SBC: begin
        // Two's complement add; carry-in of one unless a borrow is pending
        sum9 = {1'b0, bus.a} + {1'b0, ~bus.b} + {8'h00, ~bus.fin.c};
        nib5 = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + {4'h0, ~bus.fin.c};
        bus.res = sum9[7:0];
        bus.fout.c = ~sum9[8];
        bus.fout.h = ~nib5[4];
        bus.fout.z = (sum9[7:0] == 8'h00);
        bus.fout.s = sum9[7];
        bus.fout.v = (bus.a[7] ^ bus.b[7]) & (sum9[7] ^ bus.a[7]);
        bus.fout.d = 1'b1;
        bus.wr = 1'b1;
      end
      default: begin
        bus.wr = 1'b0;
      end
    endcase
  end

endmodule : ssc_alu

`default_nettype wire

/* verif/shift_subtract_carry_ops_tb_top.sv */
// Self-checking bench for the shift, subtract and carry slice, driven over AXI4-Lite.
// Assumes the package and ssc_params.svh are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module shift_subtract_carry_ops_tb_top;
  import ssc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int bad_count = 0;
  int n_checks = 0;
  logic [1:0] rs;
  logic [31:0] rv;
  always #10 aclk = ~aclk;
  ssc_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    wr(`SSC_REG_RF_ADDR, {20'h0, a});
    wr(`SSC_REG_RF_DATA, {24'h0, d});
  endtask : poke
  task automatic peek(input logic [11:0] a);
    wr(`SSC_REG_RF_ADDR, {20'h0, a});
    rd(`SSC_REG_RF_DATA);
  endtask : peek
  // Start, then poll until idle; done without illegal must follow every legal opcode
  task automatic run(input logic [31:0] ins, input logic [1:0] st);
    wr(`SSC_REG_INSTR, ins);
    wr(`SSC_REG_CTRL, 32'h1);
    do rd(`SSC_REG_STATUS); while (rv[0] !== 1'b0);
    `CHK("status", st, rv[2:1])
  endtask : run
  function automatic logic [13:0] sbc_exp(input logic [7:0] d, input logic [7:0] s, input logic c);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, d} - {1'b0, s} - {8'h0, c};
    h = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, c};
    return {t[7:0], t[8], t[7:0] == 8'h0, t[7], (d[7] != s[7]) && (t[7] != d[7]), 1'b1, h[4]};
  endfunction : sbc_exp
  // Rotate (opcode bit 4 clear) or arithmetic shift: {result, C, Z, S, V, D, H}
  function automatic logic [13:0] sh_exp(input logic [7:0] op, input logic [7:0] v, input logic [5:0] f);
    logic [7:0] r;
    r = op[4] ? {v[7], v[7:1]} : {f[5], v[7:1]};
    return {r, v[0], r == 8'h0, r[7], op[4] ? 1'b0 : r[7] ^ v[7], f[1:0]};
  endfunction : sh_exp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin : watchdog
    #1000000;
    bad_count++;
    report_and_stop();
  end
  initial begin : main
    logic [7:0] v, a, op, d, s;
    logic [5:0] f;
    logic [3:0] g, n, p;
    logic [11:0] da, sa, xs, xd, pl;
    logic [13:0] e;
    logic [31:0] ins;
    v = $urandom(32'h1573C615);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SSC_REG_FLAGS);
    `CHK("flags reset", 32'h0, rv)
    wr(8'h40, 32'h5A);
    `CHK("unmapped write", `SSC_RESP_SLVERR, rs)
    rd(8'h40);
    `CHK("unmapped read", {`SSC_RESP_SLVERR, 32'h0}, {rs, rv})
    $display("test map done");
    for (int i = 0; i < 24; i++) begin
      g = 4'($urandom); n = 4'($urandom); v = 8'($urandom); f = 6'($urandom);
      // Page E reached through the pointer page field
      p = (i == 1) ? 4'hE : 4'($urandom_range(0, 14));
      op = (i % 2) ? `SSC_OPC_SRA_R : `SSC_OPC_RRC_R;
      a = (i % 3 == 0) ? {`SSC_ESC_NIBBLE, n} : 8'($urandom_range(8'h10, 8'hDF));
      da = (i % 3 == 0) ? {p, g, n} : {p, a};
      wr(`SSC_REG_RP, {24'h0, g, p});
      poke(da, v);
      wr(`SSC_REG_FLAGS, {24'h0, f, 2'b00});
      run({16'h0, a, op}, 2'b01);
      e = sh_exp(op, v, f);
      peek(da);
      `CHK("shift result", e[13:6], rv[7:0])
      rd(`SSC_REG_FLAGS);
      `CHK("shift flags", {e[5:0], 2'b00}, rv[7:0])
    end
    $display("test shifts done");
    for (int k = 0; k < 2; k++) begin
      f = k ? 6'($urandom) : 6'h00;
      wr(`SSC_REG_FLAGS, {24'h0, f, 2'b00});
      run({24'h0, `SSC_OPC_SCF}, 2'b01);
      rd(`SSC_REG_FLAGS);
      `CHK("carry set", {1'b1, f[4:0], 2'b00}, rv[7:0])
    end
    $display("test carry done");
    for (int i = 0; i < 20; i++) begin
      g = 4'($urandom); n = 4'($urandom); d = 8'($urandom); s = 8'($urandom); f = 6'($urandom);
      p = 4'($urandom_range(0, 13));
      if (i < 2) begin
        d = 8'h00; s = 8'h00; f[5] = i[0];
      end
      da = {p, g, n}; sa = da ^ 12'h100; xd = da; xs = sa;
      case (i % 4)
        0: begin sa = {p, g, n ^ 4'h5}; ins = {16'h0, n, n ^ 4'h5, `SSC_OPC_SBC_WW}; end
        1: begin sa = 12'($urandom_range(0, 12'hDFF)); da = sa ^ 12'h101; xs = sa; xd = da; end
        2: begin
          // Escaped source and escaped destination take turns
          if (i[2]) begin
            xs = {`SSC_ESC_BYTE, n}; sa = da; da = da ^ 12'h100; xd = da;
          end else begin
            xd = {`SSC_ESC_BYTE, n};
          end
        end
        default: begin
          sa = {p, g, n ^ 4'h5}; da = {p, 4'h3, n};
          ins = {8'h0, 4'h3, n, `SSC_ESC_NIBBLE, n ^ 4'h5, `SSC_OPC_SBC_RR};
        end
      endcase
      if (i % 4 == 1 || i % 4 == 2) ins = {xd[7:0], xs[3:0], xd[11:8], xs[11:4], `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EE};
      wr(`SSC_REG_RP, {24'h0, g, p});
      poke(da, d);
      poke(sa, s);
      wr(`SSC_REG_FLAGS, {24'h0, f, 2'b00});
      run(ins, 2'b01);
      e = sbc_exp(d, s, f[5]);
      peek(da);
      `CHK("sub result", e[13:6], rv[7:0])
      peek(sa);
      `CHK("sub source", s, rv[7:0])
      rd(`SSC_REG_FLAGS);
      `CHK("sub flags", {e[5:0], 2'b00}, rv[7:0])
    end
    $display("test subtract done");
    // Indirect, literal and extended-literal forms, plus one undefined opcode
    for (int k = 0; k < 16; k++) begin
      n = 4'($urandom); d = 8'($urandom); s = 8'($urandom); f = 6'($urandom);
      p = 4'($urandom_range(0, 14));
      sa = {p, 4'hE, n}; da = {p, 4'h3, n}; pl = {p, 4'h2, n};
      case (k % 8)
        0: begin
          pl = {p, 4'h9, n ^ 4'h5}; da = {p, 4'h9, n};
          ins = {16'h0, n, n ^ 4'h5, `SSC_OPC_SBC_WI};
        end
        1: ins = {8'h0, 4'h3, n, 4'h2, n, `SSC_OPC_SBC_RI};
        2: ins = {8'h0, s, 4'h3, n, `SSC_OPC_SBC_RM};
        3: begin da = sa; ins = {8'h0, s, 4'h2, n, `SSC_OPC_SBC_IM}; end
        4: ins = {4'h3, n, 4'h0, p, s, `SSC_OPC_SUBTRACT_BORROW_EXTENDED_EM};
        5: begin da = sa; ins = {16'h0, 4'h2, n, `SSC_OPC_RRC_I}; end
        6: begin da = sa; ins = {16'h0, 4'h2, n, `SSC_OPC_SRA_I}; end
        default: ins = {8'h0, s, 4'h3, n, 8'h3A};
      endcase
      wr(`SSC_REG_RP, {24'h0, 4'h9, p});
      // Pointer byte in E0H..EFH: only an indirect access reaches that register
      poke(pl, {4'hE, n});
      poke(da, d);
      if (k % 8 < 2) poke(sa, s);
      wr(`SSC_REG_FLAGS, {24'h0, f, 2'b00});
      run(ins, (k % 8 == 7) ? 2'b11 : 2'b01);
      e = (k % 8 == 7) ? {d, f} : (k % 8 > 4) ? sh_exp(ins[7:0], d, f) : sbc_exp(d, s, f[5]);
      peek(da);
      `CHK("mode result", e[13:6], rv[7:0])
      rd(`SSC_REG_FLAGS);
      `CHK("mode flags", {e[5:0], 2'b00}, rv[7:0])
    end
    $display("test modes done");
    report_and_stop();
  end
endmodule : shift_subtract_carry_ops_tb_top
`default_nettype wire
